/* File: logic/gpio_port_config_mux.sv */
// three eight-pin ports: mode registers, data registers and output routing
//
// Overview of operation
// [RULE1] 24 pins in three ports of eight
// [RULE2] each pin has a 4-bit mode field
// [RULE3] low register pins 3..0, high pins 7..4
// [RULE4] code 0: analog, driver off, reads 1
// [RULE5] code 4: floating input, driver off
// [RULE6] code 8: pulled input, output bit picks direction
// [RULE7] code 1: push-pull from output register
// [RULE8] open-drain codes drive low or release
// [RULE9] alternate codes take level from peripheral
// [RULE10] one driver per pin; inputs never drive
// [RULE11] digital input feeds register, peripherals, wake
// [RULE12] clear register write clears output bits
// [RULE13] set register write sets output bits
// [RULE14] wake mask picks pins that wake
// [RULE15] enabled timer channel beats serial output
// [RULE16] route bits 4..7 move timer channels
// [RULE17] serial controller mode decides its pins
// [RULE18] trace select picks packet or cpu trace
// [RULE19] alternate pin without peripheral drives 0
// [RULE20] reset returns all modes to floating input
// [RULE21] zero bits in set/clear change nothing
// [RULE22] unassigned codes act as floating input
`timescale 1ns/1ps
module gpio_port_config_mux import gpio_pkg::*; (
    input  wire logic                 i_clk,
    input  wire logic                 i_sys_rst,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [ADDR_BITS-1:0] i_paddr,
    input  wire logic [31:0]          i_pwdata,
    output logic      [31:0]          o_prdata,
    output logic                      o_pready,
    output logic                      o_pslverr,
    input  wire logic [PIN_COUNT-1:0] i_pad_in,
    output logic      [PIN_COUNT-1:0] o_pad_out,
    output logic      [PIN_COUNT-1:0] o_pad_oe,
    output logic      [PIN_COUNT-1:0] o_pad_pull_en,
    output logic      [PIN_COUNT-1:0] o_pad_pull_up,
    output logic      [PIN_COUNT-1:0] o_pad_analog,
    input  wire logic [7:0]           i_second_timer_route_bits,
    input  wire logic [3:0]           i_second_timer_channel_enables,
    input  wire logic                 i_second_timer_channel_1,
    input  wire logic                 i_second_timer_channel_2,
    input  wire logic                 i_second_timer_channel_3,
    input  wire logic                 i_second_timer_channel_4,
    input  wire logic [PIN_COUNT-1:0] i_serial_alt_out,
    input  wire logic [PIN_COUNT-1:0] i_serial_alt_own,
    input  wire logic                 i_packet_trace_frame_enable,
    input  wire logic                 i_packet_trace_bit,
    input  wire logic                 i_cpu_trace_bit_2,
    input  wire logic                 i_cpu_trace_bit_3,
    output logic      [PIN_COUNT-1:0] o_pin_level,
    output logic      [PIN_COUNT-1:0] o_wake_pins,
    output logic                      o_wake_event
);
    // ************************************************************
    // state
    // ************************************************************
    logic [15:0]          mode_low   [PORT_COUNT];
    logic [15:0]          mode_high  [PORT_COUNT];
    logic [7:0]           out_level  [PORT_COUNT];
    logic [7:0]           wake_mask  [PORT_COUNT];
    logic                 trace_sel;
    logic [PIN_COUNT-1:0] pad_sync1;
    logic [PIN_COUNT-1:0] pad_sync2;
    logic [PIN_COUNT-1:0] alt_level;
    logic [PIN_COUNT-1:0] digital_in;
    logic [PIN_COUNT-1:0] next_out;
    logic [PIN_COUNT-1:0] next_oe;
    logic [PIN_COUNT-1:0] next_pull_en;
    logic [PIN_COUNT-1:0] next_pull_up;
    logic [PIN_COUNT-1:0] next_analog;
    logic [PIN_COUNT-1:0] out_flat;
    logic [PIN_COUNT-1:0] mask_flat;
    logic [3:0]           timer_ch;
    logic [1:0]           sel_port;
    logic [4:0]           sel_ofs;
    logic                 sel_valid;
    logic                 wr_strobe;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [3:0] pin_mode(input logic [15:0] lo, input logic [15:0] hi,
                                            input int idx);
        logic [15:0] word;
        word = (idx < 4) ? lo : hi; // [RULE3]
        return word[(idx % 4) * MODE_BITS +: MODE_BITS]; // [RULE2]
    endfunction

    function automatic logic in_mode(input logic [3:0] m);
        return (m != MODE_OUT_PP) && (m != MODE_OUT_OD) &&
               (m != MODE_ALT_PP) && (m != MODE_ALT_OD);
    endfunction

    // ************************************************************
    // apb decode
    // ************************************************************
    assign o_pready  = 1'b1;
    assign wr_strobe = i_psel && i_penable && i_pwrite;

    always_comb begin
        sel_port  = 2'd0;
        sel_ofs   = i_paddr[4:0];
        sel_valid = 1'b0;
        if (i_paddr == ADDR_TRACE_SEL) begin
            sel_valid = 1'b1;
        end else if (i_paddr < PORT_STRIDE * 12'd3 && i_paddr[1:0] == 2'b00 &&
                     i_paddr[4:0] <= OFS_WAKE_MASK) begin
            sel_port  = i_paddr[6:5]; // [RULE1]
            sel_valid = 1'b1;
        end
    end

    // unmapped or misaligned words fail the access; reads give zero
    assign o_pslverr = i_psel && i_penable && !sel_valid;

    // ************************************************************
    // configuration and data registers
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (int p = 0; p < PORT_COUNT; p++) begin
                mode_low[p]  <= RST_MODE; // [RULE20]
                mode_high[p] <= RST_MODE; // [RULE20]
            end
        end else if (wr_strobe && sel_valid && i_paddr != ADDR_TRACE_SEL) begin
            if (sel_ofs == OFS_MODE_LOW) begin
                mode_low[sel_port] <= i_pwdata[15:0]; // [RULE3]
            end else if (sel_ofs == OFS_MODE_HIGH) begin
                mode_high[sel_port] <= i_pwdata[15:0]; // [RULE3]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (int p = 0; p < PORT_COUNT; p++) begin
                out_level[p] <= RST_OUT_LEVEL;
            end
        end else if (wr_strobe && sel_valid && i_paddr != ADDR_TRACE_SEL) begin
            if (sel_ofs == OFS_OUT_LEVEL) begin
                out_level[sel_port] <= i_pwdata[7:0];
            end else if (sel_ofs == OFS_OUT_SET) begin
                out_level[sel_port] <= out_level[sel_port] | i_pwdata[7:0]; // [RULE13] [RULE21]
            end else if (sel_ofs == OFS_OUT_CLEAR) begin
                out_level[sel_port] <= out_level[sel_port] & ~i_pwdata[7:0]; // [RULE12] [RULE21]
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (int p = 0; p < PORT_COUNT; p++) begin
                wake_mask[p] <= RST_WAKE_MASK;
            end
        end else if (wr_strobe && sel_valid && i_paddr != ADDR_TRACE_SEL &&
                     sel_ofs == OFS_WAKE_MASK) begin
            wake_mask[sel_port] <= i_pwdata[7:0]; // [RULE14]
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            trace_sel <= 1'b0;
        end else if (wr_strobe && i_paddr == ADDR_TRACE_SEL) begin
            trace_sel <= i_pwdata[TRACE_SEL_BIT]; // [RULE18]
        end
    end

    // read data captured in the setup cycle; zero-wait access
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= 32'h0000_0000;
            if (i_paddr == ADDR_TRACE_SEL) begin
                o_prdata[TRACE_SEL_BIT] <= trace_sel;
            end else if (sel_valid) begin
                if (sel_ofs == OFS_MODE_LOW) begin
                    o_prdata[15:0] <= mode_low[sel_port];
                end else if (sel_ofs == OFS_MODE_HIGH) begin
                    o_prdata[15:0] <= mode_high[sel_port];
                end else if (sel_ofs == OFS_PIN_LEVEL) begin
                    o_prdata[7:0] <= o_pin_level[sel_port*8 +: 8]; // [RULE11]
                end else if (sel_ofs == OFS_OUT_LEVEL) begin
                    o_prdata[7:0] <= out_level[sel_port];
                end else if (sel_ofs == OFS_WAKE_MASK) begin
                    o_prdata[7:0] <= wake_mask[sel_port];
                end
            end
        end
    end

    // ************************************************************
    // pin input synchroniser
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pad_sync1 <= '0;
            pad_sync2 <= '0;
        end else begin
            pad_sync1 <= i_pad_in;
            pad_sync2 <= pad_sync1;
        end
    end

    // ************************************************************
    // alternate output source per pin
    // ************************************************************
    assign timer_ch = {i_second_timer_channel_4, i_second_timer_channel_3,
                       i_second_timer_channel_2, i_second_timer_channel_1};

    always_comb begin
        alt_level = '0; // [RULE19]
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (i_serial_alt_own[i]) begin
                alt_level[i] = i_serial_alt_out[i]; // [RULE17]
            end
        end
        // trace overrides serial on its two pins
        alt_level[TRACE_PIN_A] = trace_sel ? i_cpu_trace_bit_2 : i_packet_trace_frame_enable; // [RULE18]
        alt_level[TRACE_PIN_B] = trace_sel ? i_cpu_trace_bit_3 : i_packet_trace_bit; // [RULE18]
        // timer last so an enabled channel wins over everything on its pin
        for (int c = 0; c < 4; c++) begin
            if (i_second_timer_channel_enables[c]) begin
                if (i_second_timer_route_bits[ROUTE_BIT_BASE + c]) begin
                    alt_level[TIMER_PIN_SET[c]] = timer_ch[c]; // [RULE15] [RULE16]
                end else begin
                    alt_level[TIMER_PIN_CLR[c]] = timer_ch[c]; // [RULE15] [RULE16]
                end
            end
        end
    end

    // ************************************************************
    // pin cells
    // ************************************************************
    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        gpio_pin_cell u_cell (
            .i_mode         (pin_mode(mode_low[g/8], mode_high[g/8], g % 8)),
            .i_out_bit      (out_level[g/8][g%8]),
            .i_alt_bit      (alt_level[g]),
            .i_pin_sync     (pad_sync2[g]),
            .o_drive_level  (next_out[g]),
            .o_drive_enable (next_oe[g]),
            .o_pull_enable  (next_pull_en[g]),
            .o_pull_up      (next_pull_up[g]),
            .o_analog       (next_analog[g]),
            .o_digital_in   (digital_in[g])
        );
        assign out_flat[g]  = out_level[g/8][g%8];
        assign mask_flat[g] = wake_mask[g/8][g%8];
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pad_out     <= '0;
            o_pad_oe      <= '0; // [RULE10]
            o_pad_pull_en <= '0;
            o_pad_pull_up <= '0;
            o_pad_analog  <= '0;
        end else begin
            o_pad_out     <= next_out;
            o_pad_oe      <= next_oe; // [RULE10]
            o_pad_pull_en <= next_pull_en;
            o_pad_pull_up <= next_pull_up;
            o_pad_analog  <= next_analog;
        end
    end

    // ************************************************************
    // input distribution and wake detection
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_pin_level  <= '1;
            o_wake_pins  <= '0;
            o_wake_event <= 1'b0;
        end else begin
            o_pin_level  <= digital_in; // [RULE11]
            o_wake_pins  <= digital_in & mask_flat; // [RULE14]
            // a change on any masked pin; analog pins are held high, so only a switch into or out of analog mode against a low level can wake
            o_wake_event <= |((digital_in ^ o_pin_level) & mask_flat); // [RULE11] [RULE14]
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence apb_setup(logic [11:0] a);
        i_psel && !i_penable && i_paddr == a;
    endsequence
    sequence apb_write(logic [11:0] a);
        apb_setup(a) ##1 (i_psel && i_penable && i_pwrite && i_paddr == a);
    endsequence

    logic [PIN_COUNT-1:0] in_mode_vec;
    logic [PIN_COUNT-1:0] od_mode_vec;
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            in_mode_vec[i] = in_mode(pin_mode(mode_low[i/8], mode_high[i/8], i % 8));
            od_mode_vec[i] = pin_mode(mode_low[i/8], mode_high[i/8], i % 8) == MODE_OUT_OD ||
                             pin_mode(mode_low[i/8], mode_high[i/8], i % 8) == MODE_ALT_OD;
        end
    end

    reset_mode_a: assert property ($fell(i_sys_rst) |-> // [RULE20]
        mode_low[0] == RST_MODE && mode_high[2] == RST_MODE)
        else $error("mode not floating input after reset");

    set_write_a: assert property (apb_write(12'h010) |=> // [RULE13]
        (out_level[0] & $past(i_pwdata[7:0])) == $past(i_pwdata[7:0]))
        else $error("set write did not set bits");

    clear_write_a: assert property (apb_write(12'h054) |=> // [RULE12]
        (out_level[2] & $past(i_pwdata[7:0])) == 8'h00)
        else $error("clear write did not clear bits");

    set_zero_bits_a: assert property (apb_write(12'h010) |=> // [RULE21]
        (out_level[0] & ~$past(i_pwdata[7:0])) == ($past(out_level[0]) & ~$past(i_pwdata[7:0])))
        else $error("set write disturbed zero bits");

    input_no_drive_a: assert property ((($past(in_mode_vec) & o_pad_oe) == '0)) // [RULE10]
        else $error("pin driven while in input or analog mode");

    open_drain_low_a: assert property (((($past(od_mode_vec) & o_pad_out) == '0))) // [RULE8]
        else $error("open-drain pin drove high");

    analog_read_a: assert property (pin_mode(mode_low[0], mode_high[0], 0) == MODE_ANALOG // [RULE4]
        ##1 pin_mode(mode_low[0], mode_high[0], 0) == MODE_ANALOG |-> o_pin_level[0])
        else $error("analog pin did not read one");

    timer_priority_a: assert property (i_second_timer_channel_enables[0] && // [RULE15]
        i_second_timer_route_bits[ROUTE_BIT_BASE] && i_serial_alt_own[9] &&
        pin_mode(mode_low[1], mode_high[1], 1) == MODE_ALT_PP |=>
        o_pad_out[9] == $past(i_second_timer_channel_1))
        else $error("timer channel lost to serial output");

    no_peripheral_a: assert property (!i_serial_alt_own[23] && // [RULE19]
        pin_mode(mode_low[2], mode_high[2], 7) == MODE_ALT_PP |=> o_pad_oe[23] && !o_pad_out[23])
        else $error("alternate pin without source not driven low");
endmodule // gpio_port_config_mux

/* File: common/gpio_pkg.sv */
// constants for the three-port pin configuration and routing block
package gpio_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int PORT_COUNT = 3;
    localparam int PORT_PINS  = 8;
    localparam int PIN_COUNT  = PORT_COUNT * PORT_PINS;
    localparam int MODE_BITS  = 4;
    localparam int ADDR_BITS  = 12;
    // ************************************************************
    // register map, one block of words per port
    // ************************************************************
    localparam logic [11:0] PORT_STRIDE    = 12'h020;
    localparam logic [4:0]  OFS_MODE_LOW   = 5'h00;
    localparam logic [4:0]  OFS_MODE_HIGH  = 5'h04;
    localparam logic [4:0]  OFS_PIN_LEVEL  = 5'h08;
    localparam logic [4:0]  OFS_OUT_LEVEL  = 5'h0c;
    localparam logic [4:0]  OFS_OUT_SET    = 5'h10;
    localparam logic [4:0]  OFS_OUT_CLEAR  = 5'h14;
    localparam logic [4:0]  OFS_WAKE_MASK  = 5'h18;
    localparam logic [11:0] ADDR_TRACE_SEL = 12'h060;
    localparam int          TRACE_SEL_BIT  = 0;
    // ************************************************************
    // mode codes and reset values
    // ************************************************************
    localparam logic [3:0]  MODE_ANALOG    = 4'h0;
    localparam logic [3:0]  MODE_OUT_PP    = 4'h1;
    localparam logic [3:0]  MODE_IN_FLOAT  = 4'h4;
    localparam logic [3:0]  MODE_OUT_OD    = 4'h5;
    localparam logic [3:0]  MODE_IN_PULL   = 4'h8;
    localparam logic [3:0]  MODE_ALT_PP    = 4'h9;
    localparam logic [3:0]  MODE_ALT_OD    = 4'hd;
    localparam logic [15:0] RST_MODE       = 16'h4444;
    localparam logic [7:0]  RST_OUT_LEVEL  = 8'h00;
    localparam logic [7:0]  RST_WAKE_MASK  = 8'h00;
    // ************************************************************
    // second timer channel routing: pin index when route bit clear / set
    // ************************************************************
    localparam int ROUTE_BIT_BASE = 4;
    localparam int TIMER_PIN_CLR [4] = '{0, 3, 1, 2};
    localparam int TIMER_PIN_SET [4] = '{9, 10, 11, 12};
    localparam int TRACE_PIN_A    = 4;
    localparam int TRACE_PIN_B    = 5;
endpackage

/* File: logic/gpio_pin_cell.sv */
// per-pin mode decode: driver, pull resistor and digital input path
`timescale 1ns/1ps
module gpio_pin_cell import gpio_pkg::*; (
    input  wire logic [3:0] i_mode,
    input  wire logic       i_out_bit,
    input  wire logic       i_alt_bit,
    input  wire logic       i_pin_sync,
    output logic            o_drive_level,
    output logic            o_drive_enable,
    output logic            o_pull_enable,
    output logic            o_pull_up,
    output logic            o_analog,
    output logic            o_digital_in
);
    always_comb begin
        o_drive_level  = 1'b0;
        o_drive_enable = 1'b0;
        o_pull_enable  = 1'b0;
        o_pull_up      = 1'b0;
        o_analog       = 1'b0;
        o_digital_in   = i_pin_sync;
        case (i_mode)
            MODE_ANALOG: begin
                o_analog     = 1'b1;
                o_digital_in = 1'b1; // [RULE4]
            end
            MODE_IN_PULL: begin
                o_pull_enable = 1'b1; // [RULE6]
                o_pull_up     = i_out_bit; // [RULE6]
            end
            MODE_OUT_PP: begin
                o_drive_level  = i_out_bit; // [RULE7]
                o_drive_enable = 1'b1;
            end
            MODE_OUT_OD: begin
                // only ever pulls low; high level needs an external pull-up
                o_drive_enable = ~i_out_bit; // [RULE8]
            end
            MODE_ALT_PP: begin
                o_drive_level  = i_alt_bit; // [RULE9]
                o_drive_enable = 1'b1;
            end
            MODE_ALT_OD: begin
                o_drive_enable = ~i_alt_bit; // [RULE8] [RULE9]
            end
            default: begin
                // floating input and any unassigned code: driver off
                o_drive_enable = 1'b0; // [RULE5] [RULE10] [RULE22]
            end
        endcase
    end
endmodule // gpio_pin_cell

/* File: verification/pin_world.sv */
// behavioural pad ring model: resolves each pin from drive, pull and board level
`timescale 1ns/1ps
module pin_world import gpio_pkg::*; (
    input  wire logic [PIN_COUNT-1:0] i_pad_out,
    input  wire logic [PIN_COUNT-1:0] i_pad_oe,
    input  wire logic [PIN_COUNT-1:0] i_pad_pull_en,
    input  wire logic [PIN_COUNT-1:0] i_pad_pull_up,
    input  wire logic [PIN_COUNT-1:0] i_board_level,
    output logic      [PIN_COUNT-1:0] o_pad_in
);
    // no pull on a released pin: the board level wins, open-drain highs need it
    always_comb begin
        for (int k = 0; k < PIN_COUNT; k++) begin
            if (i_pad_oe[k]) begin
                o_pad_in[k] = i_pad_out[k];
            end else if (i_pad_pull_en[k]) begin
                o_pad_in[k] = i_pad_pull_up[k];
            end else begin
                o_pad_in[k] = i_board_level[k];
            end
        end
    end
endmodule // pin_world

/* File: verification/gpio_port_config_mux_bench.sv */
// self-checking bench for the pin configuration and routing block
`timescale 1ns/1ps
module gpio_port_config_mux_bench import gpio_pkg::*;;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err, ptf = 0, ptb = 0;
    logic        ct2 = 0, ct3 = 0, ch1 = 0, ch2 = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic [23:0] pout, poe, ppe, ppu, pan, pin, lvl, wk, sout = 0, sown = 0;
    logic [23:0] board = 24'h5a3c00;
    logic [7:0]  route = 0;
    logic [3:0]  ten = 0;
    logic        rdy, slverr, wev;
    logic [3:0]  code [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd, 4'h2};
    logic [5:0]  expv [8] = '{6'h21, 6'h38, 6'h00, 6'h00, 6'h26, 6'h10, 6'h10, 6'h00};
    wire  [5:0]  pin0_view = {lvl[0], poe[0], pout[0], ppe[0], ppu[0], pan[0]};
    int          fail_count = 0, cmp_count = 0;
    initial forever #4 clk = ~clk;
    gpio_port_config_mux i_gpio_port_config_mux (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(rdy), .o_pslverr(slverr), .i_pad_in(pin), .o_pad_out(pout), .o_pad_oe(poe),
        .o_pad_pull_en(ppe), .o_pad_pull_up(ppu), .o_pad_analog(pan),
        .i_second_timer_route_bits(route), .i_second_timer_channel_enables(ten),
        .i_second_timer_channel_1(ch1), .i_second_timer_channel_2(ch2),
        .i_second_timer_channel_3(1'b0), .i_second_timer_channel_4(1'b0),
        .i_serial_alt_out(sout), .i_serial_alt_own(sown), .i_packet_trace_frame_enable(ptf),
        .i_packet_trace_bit(ptb), .i_cpu_trace_bit_2(ct2), .i_cpu_trace_bit_3(ct3),
        .o_pin_level(lvl), .o_wake_pins(wk), .o_wake_event(wev));
    pin_world i_pin_world (.i_pad_out(pout), .i_pad_oe(poe), .i_pad_pull_en(ppe),
        .i_pad_pull_up(ppu), .i_board_level(board), .o_pad_in(pin));
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer; the wait on pready is bounded, never assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        rd = prdata;
        err = slverr;
        psel <= 0;
        pen <= 0;
        if (n >= 20) begin
            fail_count++;
            complete_run();
        end
    endtask
    function automatic logic [11:0] ad(input int p, input logic [4:0] o);
        return PORT_STRIDE * 12'(p) + {7'h00, o};
    endfunction
    initial begin
        wt(6);
        rst <= 0;
        for (int p = 0; p < 3; p++) begin
            apb(0, ad(p, OFS_MODE_LOW), 0);
            check(rd, 32'h4444);
            apb(0, ad(p, OFS_MODE_HIGH), 0);
            check(rd, 32'h4444);
            apb(0, ad(p, OFS_WAKE_MASK), 0);
            check(rd, 32'h0);
        end
        apb(1, ad(2, OFS_OUT_LEVEL), 32'ha5);
        apb(1, ad(2, OFS_OUT_SET), 32'h0f);
        apb(0, ad(2, OFS_OUT_LEVEL), 0);
        check(rd, 32'haf);
        apb(1, ad(2, OFS_OUT_CLEAR), 32'h81);
        apb(0, ad(2, OFS_OUT_LEVEL), 0);
        check(rd, 32'h2e);
        apb(1, ad(2, OFS_OUT_SET), 32'h00);
        apb(1, ad(2, OFS_OUT_CLEAR), 32'h00);
        apb(0, ad(2, OFS_OUT_LEVEL), 0);
        check(rd, 32'h2e);
        // pin 0 walks the seven assigned mode codes and unassigned code 2 with its output bit set
        apb(1, ad(0, OFS_OUT_SET), 32'h01);
        for (int i = 0; i < 8; i++) begin
            apb(1, ad(0, OFS_MODE_LOW), {28'h0000444, code[i]});
            wt(6);
            check(pin0_view, expv[i]);
        end
        // PB1 and PB2 alternate: timer channels against the serial controller
        apb(1, ad(1, OFS_MODE_LOW), 32'h4994);
        @(posedge clk);
        route <= 8'h10;
        ten <= 4'h1;
        ch1 <= 1;
        sown[9] <= 1;
        wt(3);
        check(pout[9], 1'b1);
        check(pout[10], 1'b0);
        ten <= 4'h0;
        wt(3);
        check(pout[9], 1'b0);
        sout[9] <= 1;
        wt(3);
        check(pout[9], 1'b1);
        route <= 8'h30;
        ten <= 4'h2;
        ch2 <= 1;
        wt(3);
        check(pout[10], 1'b1);
        // PA4 alternate output picks packet or cpu trace
        apb(1, ad(0, OFS_MODE_HIGH), 32'h4449);
        ptf <= 1;
        wt(3);
        check(pout[4], 1'b1);
        apb(1, ADDR_TRACE_SEL, 32'h1);
        wt(3);
        check(pout[4], 1'b0);
        // PC7 alternate with no source drives low; board holds it low too
        apb(1, ad(2, OFS_MODE_HIGH), 32'h9444);
        apb(1, ad(2, OFS_WAKE_MASK), 32'h0f);
        wt(6);
        check(wk[23:16], 8'h0a);
        check({poe[23], pout[23]}, 2'b10);
        apb(0, ad(2, OFS_PIN_LEVEL), 0);
        check(rd, 32'h5a);
        // wake pulse stands one cycle; look at it between edges
        board[16] <= 1'b1;
        wt(3);
        @(negedge clk);
        check(wev, 1'b1);
        @(negedge clk);
        check(wev, 1'b0);
        apb(0, 12'h07c, 0);
        check({err, rd}, {1'b1, 32'h0});
        complete_run();
    end
endmodule // gpio_port_config_mux_bench
